// >>> src/ipdcfg_reg.sv
`timescale 1ns/10ps
`include "ipdcfg_consts.svh"
// Functional notes
// - Register at address 0x96, all fields zero after reset.
// - Bits 15:14 pick advance angle 30, 60, 90 or 120 degrees.
// - Threshold code 0000 skips position sensing, align-and-go instead.
// - Code 0001 gives 0.4 A; codes 2 to 15 give 0.2 A x (n+1).
// - Bits 9:8 pick sense clock 12/24/47/95 Hz with matching resolution.
// - Bits 6:5 pick loop constant 0.25, 0.5, 0.75 or 1.
// - Bits 4:0 give dead time (n+1) x 40 ns, 40 ns to 1.28 us.
module ipdcfg_reg
  import ipdcfg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clock,            // System clock
  input  wire logic              rst,              // Synchronous reset
  input  wire logic [ADDR_W-1:0] reg_addr,         // Register address
  input  wire logic              reg_wr,           // Write strobe
  input  wire logic [15:0]       reg_wdata,        // Write data
  input  wire logic              reg_rd,           // Read strobe
  output logic [15:0]            reg_rdata,        // Read data
  output logic                   reg_rvalid,       // Read data valid
  output logic [1:0]             sense_advance_angle,     // Angle code
  output logic [3:0]             sense_current_threshold, // Threshold code
  output logic [1:0]             sense_clock_select,      // Clock code
  output logic [1:0]             loop_control_constant,   // Constant code
  output logic [4:0]             driver_dead_time,        // Dead time code
  output logic [7:0]             advance_deg,      // Angle in degrees
  output logic [5:0]             thr_deci_amp,     // Threshold, 0.1 A
  output logic                   align_go_start,   // Align-and-go start
  output logic [6:0]             sense_hz,         // Sense clock, Hz
  output logic [8:0]             sense_res_tick,   // Resolution, 10 ns
  output logic [2:0]             coef_quarters,    // Constant, quarters
  output logic [7:0]             dead_cycles       // Dead time, cycles
);

  if (ADDR_W < 8) begin : g_addr_chk
    $error("ipdcfg_reg: ADDR_W must be at least 8");
  end

  ipdcfg_field_if fif ();

  ipdcfg_sel2_t angle_ff;
  ipdcfg_thr_t  thr_ff;
  ipdcfg_sel2_t clk_ff;
  ipdcfg_sel2_t coef_ff;
  ipdcfg_dt_t   dt_ff;
  ipdcfg_word_t rdata_ff;
  logic         rvalid_ff;
  ipdcfg_word_t cur_word;
  logic         hit;

  assign hit = (reg_addr == ADDR_W'(`IPDCFG_ADDR));

  // Reserved bit held at zero whatever was written
  always_comb begin
    cur_word = `IPDCFG_RESET;
    cur_word[`IPDCFG_ANG_HI:`IPDCFG_ANG_LO]   = angle_ff;
    cur_word[`IPDCFG_THR_HI:`IPDCFG_THR_LO]   = thr_ff;
    cur_word[`IPDCFG_CLK_HI:`IPDCFG_CLK_LO]   = clk_ff;
    cur_word[`IPDCFG_RSV_BIT]                 = 1'b0;
    cur_word[`IPDCFG_COEF_HI:`IPDCFG_COEF_LO] = coef_ff;
    cur_word[`IPDCFG_DT_HI:`IPDCFG_DT_LO]     = dt_ff;
  end

  ipdcfg_word_t rst_word;
  assign rst_word = `IPDCFG_RESET;

  always_ff @(posedge clock) begin
    if (rst) begin
      angle_ff <= rst_word[`IPDCFG_ANG_HI:`IPDCFG_ANG_LO];
      thr_ff   <= rst_word[`IPDCFG_THR_HI:`IPDCFG_THR_LO];
      clk_ff   <= rst_word[`IPDCFG_CLK_HI:`IPDCFG_CLK_LO];
      coef_ff  <= rst_word[`IPDCFG_COEF_HI:`IPDCFG_COEF_LO];
      dt_ff    <= rst_word[`IPDCFG_DT_HI:`IPDCFG_DT_LO];
    end else if (reg_wr && hit) begin
      angle_ff <= reg_wdata[`IPDCFG_ANG_HI:`IPDCFG_ANG_LO];
      thr_ff   <= reg_wdata[`IPDCFG_THR_HI:`IPDCFG_THR_LO];
      clk_ff   <= reg_wdata[`IPDCFG_CLK_HI:`IPDCFG_CLK_LO];
      coef_ff  <= reg_wdata[`IPDCFG_COEF_HI:`IPDCFG_COEF_LO];
      dt_ff    <= reg_wdata[`IPDCFG_DT_HI:`IPDCFG_DT_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff  <= `IPDCFG_RD_UNMAPPED;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      // Read in a write cycle returns the old word
      if (reg_rd) begin
        rdata_ff <= hit ? cur_word : `IPDCFG_RD_UNMAPPED;
      end
    end
  end

  assign fif.angle_sel = angle_ff;
  assign fif.thr_code  = thr_ff;
  assign fif.clk_sel   = clk_ff;
  assign fif.coef_sel  = coef_ff;
  assign fif.dt_code   = dt_ff;

  ipdcfg_decode u_decode (
    .clock (clock),
    .rst   (rst),
    .f     (fif.dec)
  );

  assign reg_rdata               = rdata_ff;
  assign reg_rvalid              = rvalid_ff;
  assign sense_advance_angle     = angle_ff;
  assign sense_current_threshold = thr_ff;
  assign sense_clock_select      = clk_ff;
  assign loop_control_constant   = coef_ff;
  assign driver_dead_time        = dt_ff;
  assign advance_deg             = fif.advance_deg;
  assign thr_deci_amp            = fif.thr_deci_amp;
  assign align_go_start          = fif.align_go_start;
  assign sense_hz                = fif.sense_hz;
  assign sense_res_tick          = fif.sense_res_tick;
  assign coef_quarters           = fif.coef_quarters;
  assign dead_cycles             = fif.dead_cycles;

  // Checks
  a_reset_fields_zero: assert property (
    @(posedge clock) $past(rst) |->
      (cur_word == `IPDCFG_RESET) && (dead_cycles == 8'h04)
      && align_go_start && (advance_deg == 8'h1E))
    else $error("fields not zero after reset");

  a_write_takes_effect: assert property (
    @(posedge clock) disable iff (rst)
    (reg_wr && hit) |=> (cur_word == ($past(reg_wdata) & 16'hFF7F)))
    else $error("write to config register not stored");

  a_angle_decode: assert property (
    @(posedge clock) disable iff (rst)
    ##1 advance_deg == 8'(({6'h00, $past(angle_ff)} + 8'h01) * 8'h1E))
    else $error("advance angle decode wrong");

  a_skip_on_zero: assert property (
    @(posedge clock) disable iff (rst)
    (thr_ff == 4'h0) ##1 (thr_ff == 4'h0) |->
      align_go_start && (thr_deci_amp == 6'h00))
    else $error("zero threshold code does not skip sensing");

  a_threshold_decode: assert property (
    @(posedge clock) disable iff (rst)
    ($stable(thr_ff) && thr_ff != 4'h0) |=> !align_go_start
      && (thr_deci_amp == (($past(thr_ff) == 4'h1) ? 6'h04
        : 6'(({2'b00, $past(thr_ff)} + 6'h01) * 6'h02))))
    else $error("threshold decode wrong");

  a_sense_clock_pair: assert property (
    @(posedge clock) disable iff (rst)
    (clk_ff == 2'h3) ##1 (clk_ff == 2'h3) |->
      (sense_hz == 7'h5F) && (sense_res_tick == 9'h020))
    else $error("fastest sense clock pair wrong");

  a_sense_res_tie: assert property (
    @(posedge clock) disable iff (rst)
    ##1 (sense_res_tick == (9'h100 >> $past(clk_ff))))
    else $error("sense resolution decode wrong");

  a_reserved_reads_zero: assert property (
    @(posedge clock) disable iff (rst)
    reg_rvalid |-> !reg_rdata[`IPDCFG_RSV_BIT])
    else $error("reserved bit read back non-zero");

  a_read_returns_word: assert property (
    @(posedge clock) disable iff (rst)
    (reg_rd && hit && !reg_wr) |=> reg_rvalid
      && (reg_rdata == $past(cur_word)))
    else $error("read data does not match register");

  a_constant_decode: assert property (
    @(posedge clock) disable iff (rst)
    ##1 coef_quarters == 3'({1'b0, $past(coef_ff)} + 3'h1))
    else $error("loop constant decode wrong");

  a_dead_time_decode: assert property (
    @(posedge clock) disable iff (rst)
    ##1 dead_cycles == 8'(({3'h0, $past(dt_ff)} + 8'h01) * 8'h04))
    else $error("dead time decode wrong");

  c_write_hit: cover property (
    @(posedge clock) disable iff (rst) reg_wr && hit);

  c_read_miss: cover property (
    @(posedge clock) disable iff (rst) reg_rd && !hit);

  c_max_dead_time: cover property (
    @(posedge clock) disable iff (rst) dead_cycles == 8'h80);

  c_low_threshold: cover property (
    @(posedge clock) disable iff (rst) thr_deci_amp == 6'h04);

  c_read_write_same: cover property (
    @(posedge clock) disable iff (rst) reg_rd && reg_wr && hit);

  a_miss_write_kept: assert property (
    @(posedge clock) disable iff (rst)
    (reg_wr && !hit) |=> $stable(cur_word))
    else $error("write to other address changed register");

  a_miss_read_zero: assert property (
    @(posedge clock) disable iff (rst)
    (reg_rd && !hit) |=> reg_rvalid
      && (reg_rdata == `IPDCFG_RD_UNMAPPED))
    else $error("read of other address not zero");

  a_rvalid_pulse: assert property (
    @(posedge clock) disable iff (rst)
    reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");

  a_rdata_holds: assert property (
    @(posedge clock) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

endmodule : ipdcfg_reg

// >>> src/ipdcfg_consts.svh
`ifndef IPDCFG_CONSTS_SVH
`define IPDCFG_CONSTS_SVH

// Register placement
`define IPDCFG_ADDR          8'h96
`define IPDCFG_RESET         16'h0000
`define IPDCFG_RD_UNMAPPED   16'h0000

// Decoded reset levels
`define IPDCFG_SKIP_RST      1'b1
`define IPDCFG_COEF_RST_Q    3'h1

// Field positions
`define IPDCFG_ANG_HI        15
`define IPDCFG_ANG_LO        14
`define IPDCFG_THR_HI        13
`define IPDCFG_THR_LO        10
`define IPDCFG_CLK_HI        9
`define IPDCFG_CLK_LO        8
`define IPDCFG_RSV_BIT       7
`define IPDCFG_COEF_HI       6
`define IPDCFG_COEF_LO       5
`define IPDCFG_DT_HI         4
`define IPDCFG_DT_LO         0

// Advance angle: (code + 1) x 30 degrees
`define IPDCFG_ANG_STEP_DEG  8'h1E

// Threshold in units of 0.1 A
`define IPDCFG_THR_SKIP      4'h0
`define IPDCFG_THR_LOW_CODE  4'h1
`define IPDCFG_THR_LOW_DA    6'h04
`define IPDCFG_THR_STEP_DA   6'h02
`define IPDCFG_THR_OFF_DA    6'h00

// Sense clock in Hz, resolution in 10 ns ticks (2.56 us at code 0)
`define IPDCFG_CLK_HZ_0      7'h0C
`define IPDCFG_CLK_HZ_1      7'h18
`define IPDCFG_CLK_HZ_2      7'h2F
`define IPDCFG_CLK_HZ_3      7'h5F
`define IPDCFG_RES_NS_0      2560
`define IPDCFG_RES_TICK_0    9'h100

// Dead time: (code + 1) x 40 ns, in system clock cycles
`define IPDCFG_CLK_PERIOD_NS 10
`define IPDCFG_DT_STEP_NS    40
`define IPDCFG_DT_STEP_CYC \
  ((`IPDCFG_DT_STEP_NS + `IPDCFG_CLK_PERIOD_NS - 1) / `IPDCFG_CLK_PERIOD_NS)

`endif

// >>> src/ipdcfg_pkg.sv
package ipdcfg_pkg;

  typedef logic [15:0] ipdcfg_word_t;
  typedef logic [1:0]  ipdcfg_sel2_t;
  typedef logic [3:0]  ipdcfg_thr_t;
  typedef logic [4:0]  ipdcfg_dt_t;

endpackage : ipdcfg_pkg

// >>> src/ipdcfg_field_if.sv
`timescale 1ns/10ps
interface ipdcfg_field_if;
  import ipdcfg_pkg::*;

  ipdcfg_sel2_t angle_sel;
  ipdcfg_thr_t  thr_code;
  ipdcfg_sel2_t clk_sel;
  ipdcfg_sel2_t coef_sel;
  ipdcfg_dt_t   dt_code;

  logic [7:0]   advance_deg;
  logic [5:0]   thr_deci_amp;
  logic         align_go_start;
  logic [6:0]   sense_hz;
  logic [8:0]   sense_res_tick;
  logic [2:0]   coef_quarters;
  logic [7:0]   dead_cycles;

  modport cfg (
    output angle_sel, thr_code, clk_sel, coef_sel, dt_code,
    input  advance_deg, thr_deci_amp, align_go_start, sense_hz,
           sense_res_tick, coef_quarters, dead_cycles
  );

  modport dec (
    input  angle_sel, thr_code, clk_sel, coef_sel, dt_code,
    output advance_deg, thr_deci_amp, align_go_start, sense_hz,
           sense_res_tick, coef_quarters, dead_cycles
  );
endinterface : ipdcfg_field_if

// >>> src/ipdcfg_decode.sv
`timescale 1ns/10ps
`include "ipdcfg_consts.svh"
module ipdcfg_decode
  import ipdcfg_pkg::*;
(
  input  wire logic clock, // System clock
  input  wire logic rst,   // Synchronous reset, high
  ipdcfg_field_if.dec f    // Raw fields in, decoded values out
);

  always_ff @(posedge clock) begin
    if (rst) begin
      f.advance_deg <= `IPDCFG_ANG_STEP_DEG;
    end else begin
      f.advance_deg <= 8'(({6'h00, f.angle_sel} + 8'h01)
                         * `IPDCFG_ANG_STEP_DEG);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      f.align_go_start <= `IPDCFG_SKIP_RST;
      f.thr_deci_amp <= `IPDCFG_THR_OFF_DA;
    end else begin
      f.align_go_start <= (f.thr_code == `IPDCFG_THR_SKIP);
      if (f.thr_code == `IPDCFG_THR_SKIP) begin
        f.thr_deci_amp <= `IPDCFG_THR_OFF_DA;
      end else if (f.thr_code == `IPDCFG_THR_LOW_CODE) begin
        f.thr_deci_amp <= `IPDCFG_THR_LOW_DA;
      end else begin
        f.thr_deci_amp <= 6'(({2'b00, f.thr_code} + 6'h01)
                             * `IPDCFG_THR_STEP_DA);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      f.sense_hz       <= `IPDCFG_CLK_HZ_0;
      f.sense_res_tick <= `IPDCFG_RES_TICK_0;
    end else begin
      case (f.clk_sel)
        2'h0: f.sense_hz <= `IPDCFG_CLK_HZ_0;
        2'h1: f.sense_hz <= `IPDCFG_CLK_HZ_1;
        2'h2: f.sense_hz <= `IPDCFG_CLK_HZ_2;
        2'h3: f.sense_hz <= `IPDCFG_CLK_HZ_3;
        default: f.sense_hz <= `IPDCFG_CLK_HZ_0;
      endcase
      f.sense_res_tick <= `IPDCFG_RES_TICK_0 >> f.clk_sel;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      f.coef_quarters <= `IPDCFG_COEF_RST_Q;
      f.dead_cycles   <= 8'(`IPDCFG_DT_STEP_CYC);
    end else begin
      f.coef_quarters <= 3'({1'b0, f.coef_sel} + 3'h1);
      f.dead_cycles   <= 8'(({3'h0, f.dt_code} + 8'h01)
                           * 8'(`IPDCFG_DT_STEP_CYC));
    end
  end

endmodule : ipdcfg_decode

// >>> test/ipdcfg_host.sv
`timescale 1ns/10ps
module ipdcfg_host (
  input  wire logic        clock,     // System clock
  output logic [7:0]       reg_addr,  // Register address
  output logic             reg_wr,    // Write strobe
  output logic [15:0]      reg_wdata, // Write data
  output logic             reg_rd     // Read strobe
);
  logic allow_rsv;

  initial begin
    allow_rsv = 1'b0;
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end

  // One access per cycle; strobes stay up across back-to-back calls
  task automatic access(input logic wr, input logic rd,
                        input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_wr    <= wr;
    reg_rd    <= rd;
    reg_addr  <= a;
    reg_wdata <= allow_rsv ? d : (d & 16'hFF7F);
  endtask : access

  // Released bus shows inverted stale values
  task automatic idle();
    @(negedge clock);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask : idle
endmodule : ipdcfg_host

// >>> test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr, advance_deg, dead_cycles;
  logic        reg_wr, reg_rd, reg_rvalid, align_go_start;
  logic [15:0] reg_wdata, reg_rdata, cur, w;
  logic [1:0]  sense_advance_angle, sense_clock_select;
  logic [1:0]  loop_control_constant;
  logic [3:0]  sense_current_threshold, t;
  logic [4:0]  driver_dead_time;
  logic [5:0]  thr_deci_amp;
  logic [6:0]  sense_hz;
  logic [8:0]  sense_res_tick;
  logic [2:0]  coef_quarters;
  logic [15:0] exp_q[$];
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #5 clock = ~clock;

  ipdcfg_host ipdcfg_host_inst (.clock, .reg_addr, .reg_wr, .reg_wdata,
                                .reg_rd);
  ipdcfg_reg #(.ADDR_W(8)) ipdcfg_reg_inst (.clock, .rst, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
    .sense_advance_angle, .sense_current_threshold, .sense_clock_select,
    .loop_control_constant, .driver_dead_time, .advance_deg,
    .thr_deci_amp, .align_go_start, .sense_hz, .sense_res_tick,
    .coef_quarters, .dead_cycles);

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    ipdcfg_host_inst.access(1'b0, 1'b1, a, 16'h0000);
  endtask : rd

  // Release the bus, settle three cycles, then compare raw and decoded outputs
  task automatic check_fields(input logic [15:0] v);
    logic [15:0] raw_seen;
    logic [15:0] e_thr;
    logic [15:0] e_hz;
    ipdcfg_host_inst.idle();
    repeat (3) @(negedge clock);
    t = v[13:10];
    raw_seen = {sense_advance_angle, sense_current_threshold,
                sense_clock_select, 1'b0, loop_control_constant,
                driver_dead_time};
    e_thr = (t == 4'h0) ? 16'h0 : (t == 4'h1) ? 16'h4 : (t + 16'h1) * 16'h2;
    case (v[9:8])
      2'h0:    e_hz = 16'h0C;
      2'h1:    e_hz = 16'h18;
      2'h2:    e_hz = 16'h2F;
      default: e_hz = 16'h5F;
    endcase
    chk("raw", v & 16'hFF7F, raw_seen);
    chk("advance_deg", (v[15:14] + 16'h1) * 16'h1E, advance_deg);
    chk("align_go_start", 16'(t == 4'h0), align_go_start);
    chk("thr", e_thr, thr_deci_amp);
    chk("sense_hz", e_hz, sense_hz);
    chk("res", 16'h100 >> v[9:8], sense_res_tick);
    chk("coef", v[6:5] + 16'h1, coef_quarters);
    chk("dead", (v[4:0] + 16'h1) * 16'h4, dead_cycles);
  endtask : check_fields

  always @(negedge clock) begin
    if (!rst && reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("rvalid", 16'h0, 16'h1);
      else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h65bc56a9));
    repeat (20) @(negedge clock);
    rst <= 1'b0;
    rd(8'h96, 16'h0000);
    check_fields(16'h0000);
    $display("test reset done");
    ipdcfg_host_inst.allow_rsv = 1'b1;
    for (int i = 0; i < 32; i++) begin
      w = {i[1:0], i[3:0], i[1:0], 1'b1, i[1:0], i[4:0]};
      ipdcfg_host_inst.access(1'b1, 1'b0, 8'h96, w);
      rd(8'h96, w & 16'hFF7F);
      check_fields(w);
    end
    cur = w & 16'hFF7F;
    $display("test field codes done");
    ipdcfg_host_inst.access(1'b1, 1'b0, 8'h95, 16'h5A5A);
    rd(8'h95, 16'h0000);
    rd(8'h96, cur);
    w = 16'hFFFF;
    exp_q.push_back(cur);
    ipdcfg_host_inst.access(1'b1, 1'b1, 8'h96, w);
    rd(8'h96, 16'hFF7F);
    check_fields(w);
    $display("test unmapped and overlap done");
    ipdcfg_host_inst.allow_rsv = 1'b0;
    repeat (16) begin
      w = 16'($urandom()) & 16'hFF7F;
      ipdcfg_host_inst.access(1'b1, 1'b0, 8'h96, w);
      rd(8'h96, w);
      check_fields(w);
    end
    $display("test random words done");
    rst <= 1'b1;
    repeat (2) @(negedge clock);
    rst <= 1'b0;
    rd(8'h96, 16'h0000);
    check_fields(16'h0000);
    $display("test second reset done");
    chk("pending reads", 16'h0, 16'(exp_q.size()));
    give_verdict();
  end
endmodule : tb_top
